// ===== logic/touch_seq_pkg.sv
// Constants, types and state layout for the touch controller reset sequencer.
// Assumes a single 250 MHz clock and supply-good levels synchronous to it.
// Notes on behaviour
// - Internal power-on reset initialises the sequencer without any external reset.
// - Reset low for at least 90 ns resets device; host holds it that long, except one 22-cycle (88 ns) glitch pulse in the bench.
// - After power-up, ready for communication after a configurable 135 to 450 ms.
// - After reset release, ready for communication after a configurable 135 to 450 ms.
// - Any absent supply stalls initialisation and blocks host communication.
// - Every reset sets a reset flag in command processor message data.
// - After reset, message-pending lines are asserted low for each configured interface.
package touch_seq_pkg;

    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned RST_MIN_NS       = 90;
    localparam int unsigned RST_MIN_CYC      = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned READY_MIN_MS     = 135;
    localparam int unsigned READY_MAX_MS     = 450;
    localparam int unsigned READY_MIN_CYC    = READY_MIN_MS * CLK_MHZ * 1000;
    localparam int unsigned READY_MAX_CYC    = READY_MAX_MS * CLK_MHZ * 1000;
    localparam int unsigned PIN_INPUT_MS     = 100;
    localparam int unsigned PIN_INPUT_CYC    = PIN_INPUT_MS * CLK_MHZ * 1000;
    localparam int unsigned CNT_W            = 27;
    localparam int unsigned RSTCNT_W         = 5;

    typedef enum logic [2:0] {
        ST_POR     = 3'b000,
        ST_STALL   = 3'b001,
        ST_HOLD    = 3'b010,
        ST_BOOT    = 3'b011,
        ST_READY   = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic core_good;
        logic analog_good;
        logic io_good;
    } supply_t;

    typedef struct packed {
        logic pend_a_n;
        logic pend_a_oe_n;
        logic pend_b_n;
        logic pend_b_oe_n;
    } pend_pins_t;

    typedef struct packed {
        seq_state_t            state;
        logic [CNT_W-1:0]      boot_cnt;
        logic [RSTCNT_W-1:0]   low_cnt;
        logic                  reset_flag;
        logic                  ready;
        pend_pins_t            pins;
    } seq_regs_t;

endpackage

// ===== logic/touch_reset_seq.sv
// Reset and power-up sequencer of a capacitive touch controller.
// Assumes the host drives the active-low reset pin and supply-good levels come from comparators.
`timescale 1ns/1ps
module touch_reset_seq #(
    parameter int unsigned READY_CYC = touch_seq_pkg::READY_MIN_CYC,
    parameter int unsigned FLOAT_CYC = touch_seq_pkg::PIN_INPUT_CYC
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   ext_reset_n_i,
    input  wire touch_seq_pkg::supply_t supplies_i,
    input  wire logic                   use_serial_b_i,
    input  wire logic                   flag_clear_i,
    output logic                        ready_o,
    output logic                        reset_flag_o,
    output touch_seq_pkg::pend_pins_t   pend_pins_o
);
    import touch_seq_pkg::*;

    seq_regs_t r_q;
    seq_regs_t r_d;
    logic      all_good;
    logic      ext_reset_seen;

    // Every supply must be present before the core may start or stay up.
    function automatic logic supplies_ok(input supply_t s);
        return s.core_good & s.analog_good & s.io_good;
    endfunction

    assign all_good = supplies_ok(supplies_i);
    // A reset only counts once the pin has been low for the minimum width.
    assign ext_reset_seen = (r_q.low_cnt >= RSTCNT_W'(RST_MIN_CYC));

    always_comb begin
        r_d = r_q;
        if (!ext_reset_n_i) begin
            if (!ext_reset_seen) begin
                r_d.low_cnt = r_q.low_cnt + RSTCNT_W'(1);
            end
        end else begin
            r_d.low_cnt = '0;
        end
        case (r_q.state)
            ST_POR: begin
                r_d.state = ST_STALL;
            end
            ST_STALL: begin
                r_d.boot_cnt = '0;
                if (all_good && ext_reset_n_i) begin
                    r_d.state = ST_BOOT;
                end
            end
            ST_HOLD: begin
                r_d.boot_cnt = '0;
                if (ext_reset_n_i) begin
                    r_d.state = all_good ? ST_BOOT : ST_STALL;
                end
            end
            ST_BOOT: begin
                if (!all_good) begin
                    r_d.state = ST_STALL;
                end else if (r_q.boot_cnt >= CNT_W'(READY_CYC - 1)) begin
                    r_d.state = ST_READY;
                end else begin
                    r_d.boot_cnt = r_q.boot_cnt + CNT_W'(1);
                end
            end
            ST_READY: begin
                if (!all_good) begin
                    r_d.state = ST_STALL;
                end
            end
            default: begin
                r_d.state = ST_POR;
            end
        endcase
        if (ext_reset_seen) begin
            r_d.state = ST_HOLD;
        end
        r_d.ready = (r_d.state == ST_READY);
        // Set wins over clear so a fresh reset is never missed.
        if ((r_d.state != ST_READY && r_q.state == ST_READY) || r_d.state == ST_HOLD) begin
            r_d.reset_flag = 1'b1;
        end else if (flag_clear_i) begin
            r_d.reset_flag = 1'b0;
        end
        // Pins float as inputs until ready, then pull low with a message pending; pin B only when use_serial_b_i is set.
        r_d.pins.pend_a_n    = 1'b0;
        r_d.pins.pend_a_oe_n = ~r_d.ready;
        r_d.pins.pend_b_n    = 1'b0;
        r_d.pins.pend_b_oe_n = ~(r_d.ready & use_serial_b_i);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_q.state      <= ST_POR;
            r_q.boot_cnt   <= '0;
            r_q.low_cnt    <= '0;
            r_q.reset_flag <= 1'b1;
            r_q.ready      <= 1'b0;
            r_q.pins       <= 4'h5;
        end else if (clk_en_i) begin
            r_q <= r_d;
        end
    end

    assign ready_o      = r_q.ready;
    assign reset_flag_o = r_q.reset_flag;
    assign pend_pins_o  = r_q.pins;

    // Building blocks for the checks below; each describes one enabled edge of the sequencer.
    sequence s_valid_low;
        clk_en_i && ext_reset_seen;
    endsequence

    sequence s_short_release;
        clk_en_i && $rose(ext_reset_n_i) && !ext_reset_seen && all_good && r_q.state == ST_READY;
    endsequence

    sequence s_boot_done;
        clk_en_i && !ext_reset_seen && all_good && r_q.state == ST_BOOT && r_q.boot_cnt == CNT_W'(READY_CYC - 1);
    endsequence

    sequence s_boot_step;
        clk_en_i && !ext_reset_seen && all_good && r_q.state == ST_BOOT && r_q.boot_cnt < CNT_W'(READY_CYC - 1);
    endsequence

    sequence s_hold_release;
        clk_en_i && !ext_reset_seen && ext_reset_n_i && r_q.state == ST_HOLD;
    endsequence

    a_ready_needs_supply: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !all_good && r_q.state != ST_POR) |=> !ready_o)
        else $error("ready while a supply is absent");

    a_stall_waits: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !ext_reset_seen && !supplies_ok(supplies_i) && r_q.state == ST_STALL) |=> r_q.state == ST_STALL)
        else $error("left stall with a supply absent");

    a_por_leaves: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && r_q.state == ST_POR) |=> r_q.state != ST_POR)
        else $error("power-on reset state stuck");

    a_por_to_stall: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !ext_reset_seen && r_q.state == ST_POR) |=> r_q.state == ST_STALL)
        else $error("power-on reset did not move to stall");

    a_short_low_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_short_release |=> ready_o)
        else $error("glitch on reset pin reset the device");

    a_long_low_resets: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_valid_low |=> !ready_o)
        else $error("valid reset pulse did not reset");

    a_valid_low_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_valid_low |=> r_q.state == ST_HOLD)
        else $error("valid reset pulse did not enter hold");

    a_hold_while_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !ext_reset_n_i && r_q.state == ST_HOLD) |=> r_q.state == ST_HOLD)
        else $error("hold left while reset pin low");

    a_low_count_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        r_q.low_cnt <= RSTCNT_W'(RST_MIN_CYC))
        else $error("reset width counter overran");

    a_release_boots: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_hold_release ##0 all_good |=> (r_q.state == ST_BOOT && r_q.boot_cnt == '0))
        else $error("release did not start boot");

    a_release_stalls: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_hold_release ##0 !all_good |=> r_q.state == ST_STALL)
        else $error("release with supply absent did not stall");

    a_boot_counts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_boot_step |=> (r_q.state == ST_BOOT && r_q.boot_cnt == $past(r_q.boot_cnt) + CNT_W'(1)))
        else $error("boot counter did not advance");

    a_boot_to_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (r_q.state == ST_BOOT && r_d.state == ST_READY) |-> (r_q.boot_cnt == CNT_W'(READY_CYC - 1)))
        else $error("ready reached at wrong count");

    a_boot_completes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_boot_done |=> ready_o)
        else $error("boot ended without ready");

    a_ready_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && ready_o && all_good && !ext_reset_seen) |=> ready_o)
        else $error("ready dropped without cause");

    a_flag_after_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && ready_o && r_d.state == ST_HOLD) |=> reset_flag_o)
        else $error("reset flag not set");

    a_flag_on_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && r_d.state == ST_HOLD) |=> reset_flag_o)
        else $error("reset flag not set in hold");

    a_supply_loss_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && ready_o && !all_good) |=> (!ready_o && reset_flag_o))
        else $error("supply loss did not flag a reset");

    a_flag_set_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && flag_clear_i && ready_o && !all_good) |=> reset_flag_o)
        else $error("clear beat a fresh reset");

    a_flag_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && flag_clear_i && ready_o && all_good && !ext_reset_seen) |=> !reset_flag_o)
        else $error("reset flag not cleared");

    a_pins_float_early: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !ready_o |-> pend_pins_o.pend_a_oe_n)
        else $error("pending line driven before ready");

    a_pin_asserts_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ready_o |-> (!pend_pins_o.pend_a_oe_n && !pend_pins_o.pend_a_n))
        else $error("pending line not asserted when ready");

    a_second_line_used: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && use_serial_b_i && r_d.ready) |=> (!pend_pins_o.pend_b_oe_n && !pend_pins_o.pend_b_n))
        else $error("second pending line not asserted");

    a_second_line_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !use_serial_b_i) |=> pend_pins_o.pend_b_oe_n)
        else $error("unused pending line driven");

    a_float_window: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $fell(pend_pins_o.pend_a_oe_n) |-> r_q.boot_cnt >= CNT_W'(FLOAT_CYC - 1))
        else $error("pending line driven inside float window");

    a_enable_freezes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !clk_en_i |=> $stable(r_q))
        else $error("state moved while clock enable low");

endmodule

// ===== verif/touch_host_model.sv
// Host model: drives the reset pin and the supply-good levels.
// Assumes a free-running ref_clk_i; changes land on its falling edge.
`timescale 1ns/1ps
module touch_host_model (
    input  wire logic              ref_clk_i,
    output logic                   reset_n_o,
    output touch_seq_pkg::supply_t supplies_o
);
    import touch_seq_pkg::*;
    // The host has no pending-line outputs, so it never drives them.
    initial begin
        reset_n_o  = 1'b1;
        supplies_o = 3'h7;
    end
    // Resets through the pin only, with the supplies left up.
    task automatic pulse(input int n);
        @(negedge ref_clk_i) reset_n_o = 1'b0;
        repeat (n) @(negedge ref_clk_i);
        reset_n_o = 1'b1;
    endtask
    // Pin is low while supplies are off; the pin is then released with analog late.
    task automatic ramp();
        @(negedge ref_clk_i) reset_n_o = 1'b0;
        supplies_o = 3'h0;
        repeat (RST_MIN_CYC) @(negedge ref_clk_i);
        supplies_o = 3'h5;
        repeat (RST_MIN_CYC) @(negedge ref_clk_i);
        reset_n_o = 1'b1;
    endtask
    // Late analog recovery takes the reset route; a pin reset stands in for the reset command,
    // since there is no command port for the deep-sleep route and its calibration.
    task automatic recover();
        pulse(RST_MIN_CYC);
    endtask
    task automatic analog_up();
        @(negedge ref_clk_i) supplies_o.analog_good = 1'b1;
    endtask
endmodule

// ===== verif/touch_reset_seq_tb.sv
// Self-checking bench for the reset sequencer.
// Assumes the host model owns the reset pin and supplies.
`timescale 1ns/1ps
module touch_reset_seq_tb;
    import touch_seq_pkg::*;
    localparam int unsigned RDY = 50;
    logic       ref_clk_i;
    logic       rst_b_i;
    logic       clk_en_i;
    logic       use_b;
    logic       clr;
    logic       ready;
    logic       flag;
    logic       pin_n;
    supply_t    sup;
    pend_pins_t pins;
    logic       pa;
    logic       pb;
    int         n;
    int         fails;
    int         check_count;
    // Pull-ups lift a pending line that the device is not driving.
    assign pa = pins.pend_a_oe_n ? 1'b1 : pins.pend_a_n;
    assign pb = pins.pend_b_oe_n ? 1'b1 : pins.pend_b_n;
    touch_reset_seq #(.READY_CYC(RDY), .FLOAT_CYC(RDY)) u_touch_reset_seq (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .ext_reset_n_i(pin_n), .supplies_i(sup), .use_serial_b_i(use_b),
        .flag_clear_i(clr), .ready_o(ready), .reset_flag_o(flag), .pend_pins_o(pins));
    touch_host_model u_touch_host_model (.ref_clk_i(ref_clk_i), .reset_n_o(pin_n), .supplies_o(sup));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Waits for ready under a bound and checks the delay.
    task automatic wait_ready();
        n = 0;
        while (pa !== 1'b0) begin
            @(negedge ref_clk_i);
            n++;
            if (n > 300) begin
                fails++;
                complete_run();
            end
        end
        check(n >= RDY && n <= RDY + 5, 2'h1);
        check(ready, 2'h1);
    endtask
    task automatic por_boot();
        @(negedge ref_clk_i) rst_b_i = 1'b1;
        check({pa, pb}, 2'h3);
        wait_ready();
        check({pa, pb}, 2'h0);
        check(flag, 2'h1);
        @(negedge ref_clk_i) clr = 1'b1;
        @(negedge ref_clk_i) clr = 1'b0;
        check(flag, 2'h0);
    endtask
    task automatic pin_reset();
        u_touch_host_model.pulse(RST_MIN_CYC - 1);
        repeat (3) @(negedge ref_clk_i);
        check({ready, flag}, 2'h2);
        u_touch_host_model.pulse(RST_MIN_CYC);
        @(negedge ref_clk_i);
        check({ready, flag}, 2'h1);
        wait_ready();
    endtask
    task automatic late_analog();
        u_touch_host_model.ramp();
        use_b = 1'b0;
        repeat (2 * RDY) @(negedge ref_clk_i);
        check({ready, pa}, 2'h1);
        u_touch_host_model.analog_up();
        wait_ready();
        check({pa, pb, flag}, 3'h3);
        u_touch_host_model.recover();
        @(negedge ref_clk_i);
        check({ready, flag}, 2'h1);
        wait_ready();
    endtask
    task automatic freeze_run();
        @(negedge ref_clk_i) clk_en_i = 1'b0;
        u_touch_host_model.pulse(RST_MIN_CYC);
        repeat (2) @(negedge ref_clk_i);
        check({ready, pa}, 2'h2);
        clk_en_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check({ready, pa}, 2'h2);
    endtask
    initial begin
        rst_b_i = 1'b0;
        clk_en_i = 1'b1;
        use_b = 1'b1;
        clr = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (6) @(negedge ref_clk_i);
        por_boot();
        pin_reset();
        late_analog();
        freeze_run();
        complete_run();
    end
endmodule
